// ==== rtl/pwrflt_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrflt_ctrl #(
  parameter int unsigned BLANK_CYC = pwrflt_pkg::BLANK_CYC,
  parameter int unsigned RETRY_CYC = pwrflt_pkg::RETRY_CYC,
  parameter int unsigned DEB_CYC = pwrflt_pkg::DEB_CYC,
  parameter int unsigned STO_CYC = pwrflt_pkg::STO_CYC,
  parameter int unsigned RCB_CYC = pwrflt_pkg::RCB_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Analog comparators and pins
  input wire pwrflt_pkg::pwrflt_sense_t sense_in,
  input wire logic high_voltage_enable,
  input wire logic low_voltage_enable,
  input wire logic limit_type_select_low,
  input wire logic limit_type_select_high,
  input wire logic reverse_block_enable,
  // Switch and fault indicator
  output logic switch_on,
  output logic fault_n_o,
  output logic fault_n_oe,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int TW = pwrflt_pkg::TMR_W;
  localparam logic [TW-1:0] BLANK_LAST = TW'(BLANK_CYC - 1);
  localparam logic [TW-1:0] RETRY_LAST = TW'(RETRY_CYC - 1);
  localparam logic [TW-1:0] DEB_LAST = TW'(DEB_CYC - 1);
  localparam logic [TW-1:0] STO_LAST = TW'(STO_CYC - 1);
  localparam logic [TW-1:0] RCB_LAST = TW'(RCB_CYC - 1);

  typedef enum logic [2:0] {S_OFF, S_DEB, S_ON, S_RETRY, S_THERM, S_LATCH, S_RCB} pwrflt_state_t;

  // Synchronised inputs
  logic [pwrflt_pkg::SYNC_W-1:0] sync_bus;
  pwrflt_pkg::pwrflt_sense_t sense;
  logic high_voltage_enable_s, lven_s, sel_lo_s, sel_hi_s, rben_s;

  pwrflt_sync #(.W(pwrflt_pkg::SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({sense_in, high_voltage_enable, low_voltage_enable, limit_type_select_low,
               limit_type_select_high, reverse_block_enable}),
    .sync_out(sync_bus)
  );
  assign {sense, high_voltage_enable_s, lven_s, sel_lo_s, sel_hi_s, rben_s} = sync_bus;

  pwrflt_state_t state_reg, state_next;
  pwrflt_pkg::pwrflt_mode_t mode_reg, mode_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [TW-1:0] blank_reg, blank_next;
  logic startup_done_reg, startup_done_next;
  logic startup_fault_reg, startup_fault_next;
  logic high_voltage_enable_prev_reg, lven_prev_reg;
  logic switch_reg, flag_reg;
  logic [31:0] ctrl_reg;

  // Enable decode and toggle detection
  wire enabled = !(high_voltage_enable_s && !lven_s);
  wire en_toggle = (high_voltage_enable_s != high_voltage_enable_prev_reg) || (lven_s != lven_prev_reg);
  wire force_off = ctrl_reg[pwrflt_pkg::CTRL_FORCE_OFF];
  wire blocked = !enabled || sense.undervoltage_lockout || sense.overvoltage_lockout ||
                 sense.current_set_pin_gnd || force_off;
  wire ready_to_start = !blocked && !sense.over_temp;
  wire mode_is_cont = (mode_reg == pwrflt_pkg::MODE_CONT);
  wire blank_expired = sense.overcurrent && !mode_is_cont && (blank_reg == BLANK_LAST);
  wire sto_expired = !startup_done_reg && (timer_reg == STO_LAST);
  wire rev_active = rben_s && sense.reverse_trip;
  wire [1:0] sel = {sel_hi_s, sel_lo_s};
  wire pwrflt_pkg::pwrflt_mode_t sel_mode = (sel == pwrflt_pkg::SEL_LATCH) ? pwrflt_pkg::MODE_LATCH :
                                            (sel == pwrflt_pkg::SEL_RETRY) ? pwrflt_pkg::MODE_RETRY :
                                            pwrflt_pkg::MODE_CONT;
  wire timer_inc_on = (state_reg == S_ON) && !startup_done_reg;
  wire [TW-1:0] timer_plus = timer_reg + TW'(1);

  always_comb begin
    state_next = state_reg;
    timer_next = timer_plus;
    mode_next = mode_reg;
    startup_done_next = startup_done_reg;
    startup_fault_next = startup_fault_reg;
    case (state_reg)
      S_OFF: begin
        if (ready_to_start) begin
          state_next = S_DEB;
        end
      end
      S_DEB: begin
        if (timer_reg == DEB_LAST) begin
          state_next = S_ON;
          startup_done_next = 1'b0;
        end
      end
      S_ON: begin
        if (!timer_inc_on) begin
          timer_next = timer_reg;
        end
        if (sense.over_temp) begin
          state_next = S_THERM;
        end else if (rev_active) begin
          state_next = S_RCB;
        end else if (blank_expired) begin
          state_next = (mode_reg == pwrflt_pkg::MODE_RETRY) ? S_RETRY : S_LATCH;
        end else if (sto_expired) begin
          if (!sense.out_charged) begin
            state_next = S_LATCH;
            startup_fault_next = 1'b1;
          end else begin
            startup_done_next = 1'b1;
            mode_next = sel_mode;
          end
        end
      end
      S_RETRY: begin
        if (timer_reg == RETRY_LAST) begin
          state_next = S_ON;
          startup_done_next = 1'b0;
        end
      end
      S_THERM: begin
        if (mode_reg == pwrflt_pkg::MODE_LATCH) begin
          state_next = S_LATCH;
        end else if (sense.temp_cooled && !sense.over_temp) begin
          state_next = mode_is_cont ? S_DEB : S_RETRY;
        end
      end
      S_RCB: begin
        if (timer_reg == RCB_LAST) begin
          state_next = S_ON;
          startup_done_next = 1'b0;
        end
      end
      S_LATCH: begin
        timer_next = timer_reg;
      end
      default: begin
        state_next = S_OFF;
      end
    endcase
    // Supply loss or enable change releases the latch; other blocks force off
    if ((state_reg == S_LATCH) && (en_toggle || sense.undervoltage_lockout)) begin
      state_next = S_OFF;
      startup_fault_next = 1'b0;
    end else if ((state_reg != S_LATCH) && (state_reg != S_OFF) && blocked) begin
      state_next = S_OFF;
    end
    if (state_next != state_reg) begin
      timer_next = '0;
    end
  end

  // Blanking counter runs only while overcurrent lasts in a timed mode
  assign blank_next = (state_reg == S_ON && sense.overcurrent && !mode_is_cont && !blank_expired) ?
                      blank_reg + TW'(1) : '0;

  wire switch_next = (state_next == S_ON) && !sense.over_temp && !blocked;
  wire flag_next = sense.drop_high || rev_active || sense.over_temp || sense.current_set_pin_gnd ||
                   sense.undervoltage_lockout || sense.overvoltage_lockout || startup_fault_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_OFF;
      mode_reg <= pwrflt_pkg::MODE_CONT;
      timer_reg <= '0;
      blank_reg <= '0;
      startup_done_reg <= 1'b0;
      startup_fault_reg <= 1'b0;
      high_voltage_enable_prev_reg <= 1'b0;
      lven_prev_reg <= 1'b0;
      switch_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      timer_reg <= timer_next;
      blank_reg <= blank_next;
      startup_done_reg <= startup_done_next;
      startup_fault_reg <= startup_fault_next;
      high_voltage_enable_prev_reg <= high_voltage_enable_s;
      lven_prev_reg <= lven_s;
      switch_reg <= switch_next;
      flag_reg <= flag_next;
    end
  end

  assign switch_on = switch_reg;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = flag_reg;

  // AXI4-Lite slave
  logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  wire wr_ctrl = do_write && (awaddr_reg == pwrflt_pkg::REG_CTRL);
  wire wr_ok = wr_ctrl || (awaddr_reg == pwrflt_pkg::REG_STATUS) || (awaddr_reg == pwrflt_pkg::REG_CAUSE);
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] status_word = {24'h00_0000, startup_fault_reg, startup_done_reg, mode_reg,
                             flag_reg, switch_reg, state_reg == S_LATCH, enabled};
  wire [31:0] cause_word = {23'h00_0000, sense};
  wire ar_ok = (s_axi_araddr == pwrflt_pkg::REG_CTRL) || (s_axi_araddr == pwrflt_pkg::REG_STATUS) ||
               (s_axi_araddr == pwrflt_pkg::REG_CAUSE);
  wire [31:0] rd_word = (s_axi_araddr == pwrflt_pkg::REG_CTRL) ? ctrl_reg :
                        (s_axi_araddr == pwrflt_pkg::REG_STATUS) ? status_word :
                        (s_axi_araddr == pwrflt_pkg::REG_CAUSE) ? cause_word : 32'h0000_0000;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= pwrflt_pkg::RESP_OKAY;
      ctrl_reg <= pwrflt_pkg::CTRL_RESET;
    end else begin
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? pwrflt_pkg::RESP_OKAY : pwrflt_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~strb_mask) | (wdata_reg & strb_mask);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= pwrflt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= ar_ok ? pwrflt_pkg::RESP_OKAY : pwrflt_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_thermal_cooled;
    state_reg == S_THERM && mode_reg != pwrflt_pkg::MODE_LATCH && sense.temp_cooled &&
      !sense.over_temp && !blocked;
  endsequence

  property p_blank_trip;
    blank_expired && state_reg == S_ON && !sense.over_temp && !rev_active && !blocked |=> !switch_reg;
  endproperty
  a_blank_trip: assert property (p_blank_trip) else $error("blanking expiry left switch on");

  property p_blank_clear;
    !sense.overcurrent |=> blank_reg == '0;
  endproperty
  a_blank_clear: assert property (p_blank_clear) else $error("blanking count not cleared");

  property p_latch_hold;
    state_reg == S_LATCH && !en_toggle && !sense.undervoltage_lockout |=> state_reg == S_LATCH && !switch_reg;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched off state released early");

  property p_cont_stays_on;
    state_reg == S_ON && mode_is_cont && startup_done_reg && !sense.over_temp && !rev_active && !blocked
      ##1 state_reg == S_ON |-> switch_reg;
  endproperty
  a_cont_stays_on: assert property (p_cont_stays_on) else $error("continuous mode switched off");

  property p_flag_drop;
    sense.drop_high |=> fault_n_oe && !fault_n_o;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("drop above threshold not flagged");

  property p_flag_causes;
    !(sense.drop_high || rev_active || sense.over_temp || sense.current_set_pin_gnd ||
      sense.undervoltage_lockout || sense.overvoltage_lockout || startup_fault_reg) |=> !fault_n_oe;
  endproperty
  a_flag_causes: assert property (p_flag_causes) else $error("fault flagged without cause");

  property p_open_drain;
    fault_n_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("fault pin driven high");

  property p_overtemp_off;
    sense.over_temp |=> !switch_reg && fault_n_oe;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off) else $error("overtemperature left switch on");

  property p_thermal_exit;
    state_reg == S_THERM && !(sense.temp_cooled && !sense.over_temp) && mode_reg != pwrflt_pkg::MODE_LATCH
      && !blocked |=> state_reg == S_THERM;
  endproperty
  a_thermal_exit: assert property (p_thermal_exit) else $error("thermal exit before cooling");

  property p_thermal_path;
    s_thermal_cooled |=> state_reg == (mode_is_cont ? S_DEB : S_RETRY) && !switch_reg;
  endproperty
  a_thermal_path: assert property (p_thermal_path) else $error("wrong thermal exit path");

  property p_current_set_pin_off;
    sense.current_set_pin_gnd |=> !switch_reg && fault_n_oe;
  endproperty
  a_current_set_pin_off: assert property (p_current_set_pin_off) else $error("set pin fault ignored");

  property p_startup_fault;
    state_reg == S_ON && sto_expired && !sense.out_charged && !sense.over_temp && !rev_active && !blocked &&
      !blank_expired |=> state_reg == S_LATCH ##1 fault_n_oe;
  endproperty
  a_startup_fault: assert property (p_startup_fault) else $error("startup timeout not faulted");
endmodule // pwrflt_ctrl
`default_nettype wire

// ==== inc/pwrflt_pkg.sv ====
// Operation
// - Latch-off: overcurrent starts blanking timer; full blanking time turns switch off.
// - Blanking timer clears when overcurrent ends early; next overcurrent counts afresh.
// - Latch-off overcurrent shutdown holds until an enable toggles or supply cycles.
// - Continuous mode keeps switch conducting at the limit, no blanking shutdown.
// - Continuous mode: fault indicator follows switch drop above flag threshold.
// - Fault indicator: drop, reverse trip, overtemperature, grounded set pin, UV, OV.
// - Fault indicator is open drain, pulls low only, external pull-up.
// - Overtemperature turns switch off and flags fault in every mode.
// - Retry and continuous modes leave thermal shutdown only at the falling threshold.
// - Latch-off thermal shutdown stays latched until enable toggle or supply cycle.
// - Auto-retry thermal exit: falling threshold, then one retry interval off.
// - Continuous thermal exit: falling threshold, then debounce interval, no retry.
// - Grounded current set pin is a fault: switch off, flag asserted.
// - Output not charged at startup timeout: declare fault, switch off.
// - Power up continuous; after startup timeout sample selects: 00 latch, 01 retry, 1x cont.
// - Auto-retry: overcurrent for 24ms blanking, off 720ms, retry while fault persists.
// - Asserted fault drives the indicator output low.
package pwrflt_pkg;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned BLANK_TIME_US = 24000;
  localparam int unsigned RETRY_TIME_US = 720000;
  localparam int unsigned DEB_TIME_US = 1000;
  localparam int unsigned STO_TIME_US = 1090000;
  localparam int unsigned RCB_TIME_US = 2400;
  // Scale the clock to MHz first so the long intervals stay inside 32 bits
  localparam int unsigned BLANK_CYC = BLANK_TIME_US * (CLK_KHZ / 1000);
  localparam int unsigned RETRY_CYC = RETRY_TIME_US * (CLK_KHZ / 1000);
  localparam int unsigned DEB_CYC = DEB_TIME_US * (CLK_KHZ / 1000);
  localparam int unsigned STO_CYC = STO_TIME_US * (CLK_KHZ / 1000);
  localparam int unsigned RCB_CYC = RCB_TIME_US * (CLK_KHZ / 1000);
  localparam int TMR_W = 25;
  localparam int SYNC_W = 14;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CAUSE = 4'h8;
  localparam int CTRL_FORCE_OFF = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SEL_LATCH = 2'h0;
  localparam logic [1:0] SEL_RETRY = 2'h1;

  typedef enum logic [1:0] {MODE_LATCH, MODE_RETRY, MODE_CONT} pwrflt_mode_t;

  // Comparator results from the analog side
  typedef struct packed {
    logic overcurrent;
    logic drop_high;
    logic over_temp;
    logic temp_cooled;
    logic current_set_pin_gnd;
    logic undervoltage_lockout;
    logic overvoltage_lockout;
    logic reverse_trip;
    logic out_charged;
  } pwrflt_sense_t;
endpackage

// ==== rtl/pwrflt_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrflt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  // A bit changes only once stages two and three agree
  wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= (agree & s3_reg) | (~agree & out_reg);
    end
  end

  assign sync_out = out_reg;
endmodule // pwrflt_sync
`default_nettype wire

// ==== verif/pwrflt_analog.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrflt_analog (
  // Switch and indicator from the device
  input wire logic switch_on,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  // Scenario: 0 short,1 heavy,2 hot,3 warm,4 set gnd,5 UV,6 OV,7 reverse,8 no charge
  input wire logic [8:0] cmd,
  // Comparators and indicator line
  output var pwrflt_pkg::pwrflt_sense_t sense,
  output logic flag_pin
);
  // Load current and switch drop exist only while the switch conducts
  assign sense.overcurrent = switch_on & cmd[0];
  assign sense.drop_high = switch_on & (cmd[0] | cmd[1]);
  assign sense.over_temp = cmd[2];
  // Hysteresis: cooled only once the lower threshold is passed too
  assign sense.temp_cooled = ~cmd[3];
  assign sense.current_set_pin_gnd = cmd[4];
  assign sense.undervoltage_lockout = cmd[5];
  assign sense.overvoltage_lockout = cmd[6];
  assign sense.reverse_trip = cmd[7];
  assign sense.out_charged = switch_on & ~cmd[8];
  // External pull-up holds the line high unless the device sinks it
  assign flag_pin = fault_n_oe ? fault_n_o : 1'h1;
endmodule // pwrflt_analog
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int B = 8;
  localparam int R = 20;
  localparam int D = 4;
  localparam int S = 30;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic hv_en = 1'h0;
  logic lv_en = 1'h0;
  logic [1:0] sel = 2'h3;
  logic rbe = 1'h1;
  logic [8:0] cmd = 9'h000;
  pwrflt_pkg::pwrflt_sense_t sense;
  logic switch_on, fault_n_o, fault_n_oe, flag_pin;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [31:0] seed = 32'h7FC8E787;
  int fail_count = 0;
  int comparisons = 0;
  int k, p;
  int causes[5] = '{1, 7, 4, 5, 6};

  always #25 aclk = ~aclk;

  pwrflt_ctrl #(.BLANK_CYC(B), .RETRY_CYC(R), .DEB_CYC(D), .STO_CYC(S), .RCB_CYC(6)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .sense_in(sense),
    .high_voltage_enable(hv_en), .low_voltage_enable(lv_en),
    .limit_type_select_low(sel[0]), .limit_type_select_high(sel[1]),
    .reverse_block_enable(rbe), .switch_on(switch_on),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  pwrflt_analog i_analog (
    .switch_on(switch_on), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .cmd(cmd), .sense(sense), .flag_pin(flag_pin)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] mode_exp(input logic [1:0] s);
    return s[1] ? 2'h2 : s;
  endfunction

  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic until_sw(input logic v, input int n, input string nm);
    int i;
    for (i = 0; i < n && switch_on !== v; i++) @(posedge aclk);
    chk(nm, v, switch_on);
  endtask

  task automatic hold_sw(input logic v, input int n, input string nm);
    logic bad;
    bad = 1'h0;
    repeat (n) begin
      @(posedge aclk);
      if (switch_on !== v) bad = 1'h1;
    end
    chk(nm, 0, bad);
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    r = bresp;
    bready <= 1'h0;
    chk("bvalid", 1, bvalid);
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    chk("rvalid", 1, rvalid);
  endtask

  // Disable, re-enable and let the startup timer expire so selects are sampled
  task automatic restart(input logic [1:0] s);
    sel <= s;
    hv_en <= 1'h1;
    lv_en <= 1'h0;
    cyc(10);
    hv_en <= 1'h0;
    until_sw(1, D + 14, "restart_on");
    cyc(S + 6);
    axr(pwrflt_pkg::REG_STATUS, rd, rsp);
    chk("mode", mode_exp(s), rd[5:4]);
  endtask

  task automatic thermal_on;
    cmd[3:2] <= 2'h3;
    until_sw(0, 10, "hot_off");
    chk("hot_flag", 1, fault_n_oe);
  endtask

  initial begin
    cyc(20000);
    fail_count++;
    test_done;
  end

  initial begin
    cyc(6);
    chk("sw_rst", 0, switch_on);
    chk("flag_rst", 0, fault_n_oe);
    aresetn <= 1'h1;
    until_sw(1, D + 14, "power_on");
    chk("flag_idle", 1, flag_pin);
    axr(pwrflt_pkg::REG_STATUS, rd, rsp);
    chk("mode_pwrup", 2, rd[5:4]);
    cyc(S + 6);
    axr(pwrflt_pkg::REG_STATUS, rd, rsp);
    chk("mode_sel", mode_exp(sel), rd[5:4]);
    chk("sto_done", 1, rd[6]);
    axr(pwrflt_pkg::REG_CAUSE, rd, rsp);
    chk("cause", 9'h021, rd[8:0]);
    axr(pwrflt_pkg::REG_CTRL, rd, rsp);
    chk("ctrl_rst", pwrflt_pkg::CTRL_RESET, rd);
    seed = lfsr(seed);
    axw(pwrflt_pkg::REG_CTRL, seed | 32'h1, rsp);
    chk("bresp", pwrflt_pkg::RESP_OKAY, rsp);
    until_sw(0, 10, "force_off");
    axr(pwrflt_pkg::REG_CTRL, rd, rsp);
    chk("ctrl_rw", seed | 32'h1, rd);
    axw(pwrflt_pkg::REG_CTRL, 32'h0, rsp);
    until_sw(1, D + 14, "force_clr");
    axw(pwrflt_pkg::REG_STATUS, seed, rsp);
    chk("bresp_ro", pwrflt_pkg::RESP_OKAY, rsp);
    axw(4'hC, seed, rsp);
    chk("bresp_bad", pwrflt_pkg::RESP_SLVERR, rsp);
    axr(4'hC, rd, rsp);
    chk("rresp_bad", pwrflt_pkg::RESP_SLVERR, rsp);
    chk("rdata_bad", 0, rd);
    for (k = 1; k < 5; k++) begin
      hv_en <= k[1];
      lv_en <= k[0];
      cyc(24);
      chk("en_table", k[1:0] != 2'h2, switch_on);
    end
    cyc(S + 6);
    cmd[0] <= 1'h1;
    hold_sw(1, 3 * B, "cont_oc");
    chk("cont_flag", 1, fault_n_oe);
    cmd[0] <= 1'h0;
    cyc(8);
    chk("cont_flag_clr", 0, fault_n_oe);
    for (k = 0; k < 5; k++) begin
      cmd[causes[k]] <= 1'h1;
      cyc(2);
      chk("flag_sync", 0, fault_n_oe);
      cyc(6);
      chk("flag_set", 1, fault_n_oe);
      chk("flag_low", 0, flag_pin);
      if (causes[k] == 4) chk("current_set_pin_off", 0, switch_on);
      cmd[causes[k]] <= 1'h0;
      cyc(8);
      chk("flag_clr", 0, fault_n_oe);
      until_sw(1, S + 20, "cause_on");
    end
    // Reverse trip is ignored while reverse blocking is disabled
    rbe <= 1'h0;
    cmd[7] <= 1'h1;
    hold_sw(1, 12, "rev_ignored");
    chk("rev_ignored_flag", 0, fault_n_oe);
    cmd[7] <= 1'h0;
    rbe <= 1'h1;
    cyc(8);
    thermal_on;
    cmd[2] <= 1'h0;
    hold_sw(0, 20, "warm_cont");
    cmd[3] <= 1'h0;
    until_sw(1, D + 10, "cool_cont");
    restart(2'h0);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      p = (k == 0) ? B - 2 : 2 + seed[1:0];
      cmd[0] <= 1'h1;
      cyc(p);
      cmd[0] <= 1'h0;
      cyc(8);
    end
    chk("short_oc", 1, switch_on);
    cmd[0] <= 1'h1;
    hold_sw(1, B, "blank_latch");
    until_sw(0, 12, "latch_off");
    cmd[0] <= 1'h0;
    hold_sw(0, 40, "latched");
    lv_en <= 1'h1;
    until_sw(1, D + 14, "lv_toggle");
    cyc(S + 6);
    thermal_on;
    cmd[3:2] <= 2'h0;
    hold_sw(0, 40, "latch_hot");
    lv_en <= 1'h0;
    until_sw(1, D + 14, "hot_release");
    cmd[8] <= 1'h1;
    hv_en <= 1'h1;
    cyc(10);
    hv_en <= 1'h0;
    until_sw(1, D + 14, "sto_start");
    hold_sw(1, S - 6, "sto_run");
    until_sw(0, 14, "sto_off");
    cyc(2);
    chk("sto_flag", 1, fault_n_oe);
    cmd[8] <= 1'h0;
    lv_en <= 1'h1;
    until_sw(1, D + 14, "sto_clear");
    restart(2'h1);
    cmd[0] <= 1'h1;
    hold_sw(1, B, "blank_retry");
    until_sw(0, 12, "retry_off");
    hold_sw(0, R - 4, "retry_wait");
    until_sw(1, 12, "retry_on");
    until_sw(0, B + 14, "retry_again");
    cmd[0] <= 1'h0;
    until_sw(1, R + 12, "retry_end");
    cyc(S + 6);
    thermal_on;
    cmd[2] <= 1'h0;
    hold_sw(0, 20, "warm_retry");
    cmd[3] <= 1'h0;
    hold_sw(0, R, "hot_retry_wait");
    until_sw(1, 12, "hot_retry_on");
    test_done;
  end
endmodule // tb_top
`default_nettype wire
